// File: logic/keypad_pkg.sv
// Purpose: shared constants and types for the keypad scan controller
// Assumes: 10 MHz clock, AXI4-Lite register access, 16-bit registers in low half of word
// Notes: printed offsets are word indices; byte address is four times the index
package keypad_pkg;

  // ****************************************
  // bus and map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h041;
  localparam logic [IDX_W-1:0] IDX_KEY_MASK = 10'h050;
  localparam logic [IDX_W-1:0] IDX_COL_MASK = 10'h051;
  localparam logic [IDX_W-1:0] IDX_GPIO_CFG = 10'h052;
  localparam logic [IDX_W-1:0] IDX_GPIO_PULL = 10'h053;
  localparam logic [IDX_W-1:0] IDX_GPIO_IN = 10'h054;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // control fields and modes
  // ****************************************
  localparam int CTRL_MODE_LSB = 14;
  localparam int CTRL_DEB_LSB = 11;
  localparam int CTRL_HOLD_LSB = 8;
  localparam int COL_MASK_LSB = 12;
  localparam logic [1:0] MODE_SCAN_ONCE = 2'h0;
  localparam logic [1:0] MODE_WAIT_HOST = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;

  typedef struct packed {
    logic press_irq_state;
    logic scan_progress_state;
    logic [2:0] debounce_sel;
    logic [2:0] hold_sel;
    logic [7:0] reserved;
  } ctrl_fields_t;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] MODE_RST = MODE_OFF;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [15:0] KEY_MASK_RST = 16'h0000;
  localparam logic [3:0] COL_MASK_RST = 4'h0;
  localparam logic [7:0] GPIO_RST = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_HZ = 10_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * (CLOCK_HZ / 1_000_000);
  localparam int DEBOUNCE_MS [8] = '{2, 10, 20, 50, 60, 80, 100, 120};
  localparam int HOLD_SHORT_US = 100;
  localparam int HOLD_SHORT_TICKS = (HOLD_SHORT_US + TICK_US - 1) / TICK_US;
  localparam int TIMER_W = 14;
  localparam logic [1:0] SCAN_SAMPLE_STEP = 2'h3;

endpackage : keypad_pkg

// File: logic/interval_timer.sv
// Purpose: one-shot interval timer counting prescaled ticks
// Assumes: start and stop are one-cycle pulses; stop wins over start
// Notes: done pulses ticks*PRESCALE cycles after the start edge
`timescale 1ns/10ps
module interval_timer #(
  parameter int PRESCALE = 1000,
  parameter int WIDTH = 14
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // control
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [WIDTH-1:0] ticks_in,
  // result
  output logic done_out
);

  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

  logic busy_reg;
  logic [PW-1:0] pre_reg;
  logic [WIDTH-1:0] cnt_reg;
  wire tick = busy_reg && (pre_reg == PRE_LAST);
  wire last = cnt_reg <= WIDTH'(1);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b0;
      pre_reg <= '0;
      cnt_reg <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= !stop_in && tick && last;
      if (stop_in) begin
        busy_reg <= 1'b0;
      end else if (start_in) begin
        busy_reg <= 1'b1;
        pre_reg <= '0;
        cnt_reg <= ticks_in;
      end else if (busy_reg) begin
        pre_reg <= tick ? '0 : pre_reg + 1'b1;
        if (tick) begin
          busy_reg <= !last;
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end

endmodule : interval_timer

// File: logic/keypad_scan_controller.sv
// Purpose: 4x4 keypad scanner with AXI4-Lite registers and GPIO reuse of lines
// Assumes: key lines are synchronous inputs; rows are lines 3:0, columns lines 7:4
// Notes: scans pull columns low one at a time, wait and hold pull all enabled columns together; a low row marks a pressed key
//
// Behaviour
// - The 16-bit keypad control register is written and read back at index 0x41.
// - Bit 15 reads the press-detected flag and its write selects interrupt-started scans.
// - Bit 14 reads 0 while scanning or debouncing and 1 when key data is ready.
// - The two status bits read as press flag and data-ready flag in all four combinations.
// - Writing 00 scans once, then waits for a press, flags it and waits for the host.
// - Writing 10 stops scanning, waits for a press, flags it and then scans by itself.
// - Writing 01 stops scanning, waits for a press, flags it and waits for the host.
// - Writing 11 stops scanning and turns press detection off.
// - Bits 13:11 pick a debounce time of 2, 10, 20, 50, 60, 80, 100 or 120 ms.
// - Bits 10:8 pick the held-key wait: 100 us for code 0, else code times debounce.
// - Key mask bit k freezes key data for row k mod 4 plus 1, column k div 4 plus 1.
// - Column mask bits 15:12 hide columns 4 to 1 from detection; bits 11:0 read zero.
// - Any of the eight key lines may be turned into a general purpose line.
`timescale 1ns/10ps
module keypad_scan_controller
  import keypad_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // key lines
  input wire logic [7:0] key_line_in,
  output logic [7:0] key_line_out,
  output logic [7:0] key_line_oe_n_out,
  output logic [7:0] pullup_en_out,
  // status
  output logic press_irq_out,
  output logic [15:0] key_data_out
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT, ST_PARK, ST_DEBOUNCE, ST_SCAN, ST_HOLD
  } scan_state_t;

  scan_state_t state_reg, state_next;
  logic [1:0] mode_reg;
  logic [2:0] deb_reg;
  logic [2:0] hold_reg;
  logic press_reg, avail_reg, held_reg;
  logic [15:0] key_mask_reg, key_data_reg, key_data_next;
  logic [3:0] col_mask_reg;
  logic [7:0] gpio_sel_reg, gpio_val_reg, pull_dis_reg;
  logic [3:0] scan_cnt_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic timer_done;

  // ****************************************
  // register bus decode
  // ****************************************
  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire b_done = s_axi_bvalid_out && s_axi_bready_in;
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire r_done = s_axi_rvalid_out && s_axi_rready_in;
  wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid_out;
  wire wr_lo = do_write && w_strb_reg[0];
  wire wr_hi = do_write && w_strb_reg[1];
  wire w_mapped = aw_idx_reg inside {IDX_CTRL, IDX_KEY_MASK, IDX_COL_MASK,
                                     IDX_GPIO_CFG, IDX_GPIO_PULL, IDX_GPIO_IN};
  wire wr_ctrl = wr_hi && (aw_idx_reg == IDX_CTRL);
  wire wr_kmask_lo = wr_lo && (aw_idx_reg == IDX_KEY_MASK);
  wire wr_kmask_hi = wr_hi && (aw_idx_reg == IDX_KEY_MASK);
  wire wr_cmask = wr_hi && (aw_idx_reg == IDX_COL_MASK);
  wire wr_gsel = wr_hi && (aw_idx_reg == IDX_GPIO_CFG);
  wire wr_gval = wr_lo && (aw_idx_reg == IDX_GPIO_CFG);
  wire wr_pull = wr_lo && (aw_idx_reg == IDX_GPIO_PULL);
  wire [1:0] mode_wr = w_data_reg[CTRL_MODE_LSB +: 2];

  wire [IDX_W-1:0] r_idx = s_axi_araddr_in[ADDR_W-1:2];
  wire ctrl_fields_t ctrl_view = '{press_reg, avail_reg, deb_reg, hold_reg, 8'h00};
  wire r_mapped = r_idx inside {IDX_CTRL, IDX_KEY_MASK, IDX_COL_MASK,
                                IDX_GPIO_CFG, IDX_GPIO_PULL, IDX_GPIO_IN};
  wire [15:0] rd_word =
    (r_idx == IDX_CTRL) ? ctrl_view :
    (r_idx == IDX_KEY_MASK) ? key_mask_reg :
    (r_idx == IDX_COL_MASK) ? {col_mask_reg, 12'h000} :
    (r_idx == IDX_GPIO_CFG) ? {gpio_sel_reg, gpio_val_reg} :
    (r_idx == IDX_GPIO_PULL) ? {8'h00, pull_dis_reg} :
    (r_idx == IDX_GPIO_IN) ? {8'h00, key_line_in} : 16'h0000;

  // ****************************************
  // key line drive and sensing
  // ****************************************
  // masked columns never driven
  wire [3:0] col_en = ~col_mask_reg & ~gpio_sel_reg[7:4];
  wire [1:0] scan_col = scan_cnt_reg[3:2];
  wire [3:0] scan_onehot = 4'(4'h1 << scan_col);
  wire idle_drive = (state_reg == ST_WAIT) || (state_reg == ST_HOLD);
  wire [3:0] col_drive = (state_reg == ST_SCAN) ? (scan_onehot & col_en) :
                         idle_drive ? col_en : 4'h0;
  wire [7:0] gpio_low = gpio_sel_reg & ~gpio_val_reg;
  wire [7:0] line_oe_n_next = ~(gpio_low | {col_drive, 4'h0});
  wire drive_settled = key_line_oe_n_out == line_oe_n_next;
  wire [3:0] rows_low = ~key_line_in[3:0] & ~gpio_sel_reg[3:0];
  wire press_seen = (|rows_low) && drive_settled;

  wire scan_sample = (state_reg == ST_SCAN) && (scan_cnt_reg[1:0] == SCAN_SAMPLE_STEP);
  wire scan_last = scan_sample && (scan_col == 2'h3);
  wire [3:0] col_rows = rows_low & {4{col_en[scan_col]}};

  wire [TIMER_W-1:0] deb_ticks = TIMER_W'(DEBOUNCE_MS[deb_reg] * 1000 / TICK_US);
  wire [TIMER_W-1:0] hold_ticks = (hold_reg == 3'h0) ? TIMER_W'(HOLD_SHORT_TICKS) :
                                  TIMER_W'(int'(hold_reg) * int'(deb_ticks));

  // ****************************************
  // scan sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: state_next = ST_OFF;
      ST_WAIT: begin
        if (press_seen) begin
          state_next = (mode_reg == MODE_AUTO) ? ST_DEBOUNCE : ST_PARK;
        end
      end
      ST_PARK: state_next = ST_PARK;
      ST_DEBOUNCE: begin
        if (timer_done) begin
          state_next = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (scan_last) begin
          state_next = ((mode_reg == MODE_AUTO) && (held_reg || |col_rows)) ?
                       ST_HOLD : ST_WAIT;
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          state_next = press_seen ? ST_DEBOUNCE : ST_WAIT;
        end
      end
      default: state_next = ST_OFF;
    endcase
    if (wr_ctrl) begin
      case (mode_wr)
        MODE_SCAN_ONCE: state_next = ST_SCAN;
        MODE_OFF: state_next = ST_OFF;
        default: state_next = ST_WAIT;
      endcase
    end
  end

  wire entering = state_next != state_reg;
  wire timer_start = entering &&
                     (state_next == ST_DEBOUNCE || state_next == ST_HOLD);
  wire press_set = (state_reg == ST_WAIT) && press_seen;
  wire avail_clr = wr_ctrl || (entering && (state_next == ST_SCAN ||
                                            state_next == ST_DEBOUNCE));

  always_comb begin
    key_data_next = key_data_reg;
    if (scan_sample) begin
      for (int r = 0; r < 4; r++) begin
        if (!key_mask_reg[{scan_col, 2'(r)}]) begin
          key_data_next[{scan_col, 2'(r)}] = col_rows[r];
        end
      end
    end
  end

  interval_timer #(
    .PRESCALE(TICK_CYCLES),
    .WIDTH(TIMER_W)
  ) u_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(timer_start),
    .stop_in(wr_ctrl),
    .ticks_in((state_next == ST_HOLD) ? hold_ticks : deb_ticks),
    .done_out(timer_done)
  );

  // ****************************************
  // flip-flops
  // ****************************************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_OFF;
      scan_cnt_reg <= 4'h0;
      held_reg <= 1'b0;
      key_data_reg <= 16'h0000;
      key_line_oe_n_out <= 8'hFF;
    end else begin
      state_reg <= state_next;
      scan_cnt_reg <= (entering || state_reg != ST_SCAN) ? 4'h0 : scan_cnt_reg + 1'b1;
      held_reg <= (state_reg == ST_SCAN) && !entering && (held_reg || (scan_sample && |col_rows));
      key_data_reg <= key_data_next;
      key_line_oe_n_out <= line_oe_n_next;
    end
  end

  // press and data ready flags, set beats clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      press_reg <= 1'b0;
      avail_reg <= 1'b0;
    end else begin
      press_reg <= press_set || (press_reg && !wr_ctrl);
      avail_reg <= (scan_last && state_next != ST_SCAN) || (avail_reg && !avail_clr);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= MODE_RST;
      deb_reg <= SEL_RST;
      hold_reg <= SEL_RST;
      key_mask_reg <= KEY_MASK_RST;
      col_mask_reg <= COL_MASK_RST;
      gpio_sel_reg <= GPIO_RST;
      gpio_val_reg <= GPIO_RST;
      pull_dis_reg <= GPIO_RST;
      pullup_en_out <= 8'hFF;
    end else begin
      pullup_en_out <= ~pull_dis_reg;
      if (wr_ctrl) begin
        mode_reg <= mode_wr;
        deb_reg <= w_data_reg[CTRL_DEB_LSB +: 3];
        hold_reg <= w_data_reg[CTRL_HOLD_LSB +: 3];
      end
      if (wr_kmask_lo) key_mask_reg[7:0] <= w_data_reg[7:0];
      if (wr_kmask_hi) key_mask_reg[15:8] <= w_data_reg[15:8];
      if (wr_cmask) col_mask_reg <= w_data_reg[COL_MASK_LSB +: 4];
      if (wr_gsel) gpio_sel_reg <= w_data_reg[15:8];
      if (wr_gval) gpio_val_reg <= w_data_reg[7:0];
      if (wr_pull) pull_dis_reg <= w_data_reg[7:0];
    end
  end

  // ****************************************
  // axi4-lite handshakes
  // ****************************************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_in[ADDR_W-1:2];
        s_axi_awready_out <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in[15:0];
        w_strb_reg <= s_axi_wstrb_in[1:0];
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {16'h0000, rd_word};
      s_axi_rresp_out <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
    end
  end

  assign key_line_out = 8'h00;
  assign press_irq_out = press_reg;
  assign key_data_out = key_data_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_ctrl_readback: assert property (
    ar_take && r_idx == IDX_CTRL |=> s_axi_rvalid_out &&
      s_axi_rdata_out[15:8] == {$past(press_reg), $past(avail_reg), $past(deb_reg),
                                $past(hold_reg)})
    else $error("control readback mismatch");
  a_mode_write: assert property (
    wr_ctrl |=> mode_reg == $past(mode_wr))
    else $error("mode not taken from write");
  a_avail_after_scan: assert property (
    scan_last && !wr_ctrl |=> avail_reg && state_reg != ST_SCAN)
    else $error("data ready not set after scan");
  a_busy_not_avail: assert property (
    state_reg == ST_SCAN || state_reg == ST_DEBOUNCE |-> !avail_reg)
    else $error("data ready while scanning");
  a_press_flags: assert property (
    press_set |=> press_reg && press_irq_out)
    else $error("press not flagged");
  a_auto_debounce: assert property (
    press_set && mode_reg == MODE_AUTO && !wr_ctrl |=> state_reg == ST_DEBOUNCE)
    else $error("auto mode did not start debounce");
  a_host_park: assert property (
    press_set && mode_reg != MODE_AUTO && !wr_ctrl |=> state_reg == ST_PARK [*2])
    else $error("press did not park for host");
  a_off_quiet: assert property (
    state_reg == ST_OFF && !wr_ctrl |=> !$rose(press_reg) && key_line_oe_n_out[7:4] != 4'h0
      || gpio_sel_reg[7:4] == 4'hF)
    else $error("detection active while off");
  a_key_mask_hold: assert property (
    1'b1 |=> (key_data_reg & $past(key_mask_reg)) ==
             ($past(key_data_reg) & $past(key_mask_reg)))
    else $error("masked key data changed");
  a_gpio_drive: assert property (
    1'b1 |=> ($past(gpio_low) & key_line_oe_n_out) == 8'h00)
    else $error("gpio low not driven");

endmodule : keypad_scan_controller

// File: testbench/keypad_matrix_model.sv
// Purpose: behavioural 4x4 key matrix seen from the scanner's key lines
// Assumes: every line has a pull-up, so a released line reads high
// Notes: a pressed key joins its row and column, so a low on either side pulls the other
`timescale 1ns/10ps
module keypad_matrix_model (
  // stimulus
  input wire logic [15:0] pressed_in,
  // lines driven low by the scanner
  input wire logic [7:0] oe_n_in,
  // resolved line levels
  output logic [7:0] line_out
);
  // ****************************************
  // line resolution
  // ****************************************
  always_comb begin
    line_out = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_in[i]) line_out[i] = 1'b0;
    end
    // key k sits at row k mod 4, column k div 4
    for (int k = 0; k < 16; k++) begin
      if (pressed_in[k] && !oe_n_in[4 + k / 4]) line_out[k % 4] = 1'b0;
      if (pressed_in[k] && !oe_n_in[k % 4]) line_out[4 + k / 4] = 1'b0;
    end
  end
endmodule : keypad_matrix_model

// File: testbench/keypad_scan_controller_bench.sv
// Purpose: self-checking bench for the keypad scan controller
// Assumes: reads and write responses are checked by a monitor against queued notes
// Notes: the auto-scan test runs a full 2 ms debounce, about 20000 cycles
`timescale 1ns/10ps
module keypad_scan_controller_bench;
  import keypad_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [7:0] key_in, key_out, oe_n, pu;
  logic [15:0] key_data;
  logic [15:0] pressed = 16'h0000;
  logic [3:0] strb = 4'hF;
  logic [15:0] v;
  int bad_count = 0;
  int n_checks = 0;
  int t;
  integer seed = 32'h7D4CAFC4;
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  keypad_scan_controller uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .key_line_in(key_in),
    .key_line_out(key_out), .key_line_oe_n_out(oe_n), .pullup_en_out(pu),
    .press_irq_out(irq), .key_data_out(key_data)
  );

  keypad_matrix_model model (.pressed_in(pressed), .oe_n_in(oe_n), .line_out(key_in));

  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // ****************************************
  // tasks
  // ****************************************
  task chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [1:0] er);
    bq.push_back(er);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clock_in);
  endtask : wr

  task rd(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [1:0] er);
    rq.push_back({er, 16'h0000, d});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clock_in);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc

  task wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clock_in);
  endtask : wait_irq

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // monitor, watchdog and sequence
  // ****************************************
  always @(posedge clock_in) begin
    if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end

  initial begin
    repeat (60000) @(posedge clock_in);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rd(IDX_CTRL, 16'h0000, RESP_OKAY);
    rd(IDX_KEY_MASK, 16'h0000, RESP_OKAY);
    rd(IDX_COL_MASK, 16'h0000, RESP_OKAY);
    $display("test reset values done");
    v = 16'($random(seed));
    wr(IDX_KEY_MASK, v, RESP_OKAY);
    rd(IDX_KEY_MASK, v, RESP_OKAY);
    wr(IDX_COL_MASK, 16'hFFFF, RESP_OKAY);
    rd(IDX_COL_MASK, 16'hF000, RESP_OKAY);
    v = 16'($random(seed));
    wr(IDX_CTRL, {2'b11, v[13:0]}, RESP_OKAY);
    rd(IDX_CTRL, {2'b00, v[13:8], 8'h00}, RESP_OKAY);
    rd(10'h060, 16'h0000, RESP_SLVERR);
    wr(10'h060, v, RESP_SLVERR);
    strb <= 4'h1;
    wr(IDX_CTRL, {2'b11, ~v[13:8], 8'h00}, RESP_OKAY);
    strb <= 4'hF;
    rd(IDX_CTRL, {2'b00, v[13:8], 8'h00}, RESP_OKAY);
    wr(IDX_GPIO_CFG, 16'h0100, RESP_OKAY);
    rd(IDX_GPIO_IN, 16'h00FE, RESP_OKAY);
    wr(IDX_GPIO_PULL, 16'h00A5, RESP_OKAY);
    chk("pull-up enable", 34'h05A, {26'h0, pu});
    chk("line level", 34'h0, {26'h0, key_out});
    wr(IDX_GPIO_CFG, 16'h0000, RESP_OKAY);
    wr(IDX_GPIO_PULL, 16'h0000, RESP_OKAY);
    wr(IDX_KEY_MASK, 16'h0000, RESP_OKAY);
    wr(IDX_COL_MASK, 16'h0000, RESP_OKAY);
    wr(IDX_CTRL, 16'hC000, RESP_OKAY);
    $display("test register access done");
    pressed <= 16'h0001;
    cyc(200);
    chk("irq off mode", 34'h0, {33'h0, irq});
    wr(IDX_COL_MASK, 16'h1000, RESP_OKAY);
    wr(IDX_CTRL, 16'h4000, RESP_OKAY);
    cyc(200);
    chk("irq column masked", 34'h0, {33'h0, irq});
    wr(IDX_COL_MASK, 16'h0000, RESP_OKAY);
    wait_irq(200);
    chk("irq wait mode", 34'h1, {33'h0, irq});
    chk("key data no scan", 34'h0, {18'h0, key_data});
    rd(IDX_CTRL, 16'h8000, RESP_OKAY);
    $display("test off and masked detection done");
    pressed <= 16'h0000;
    cyc(5);
    wr(IDX_CTRL, 16'h0000, RESP_OKAY);
    cyc(50);
    rd(IDX_CTRL, 16'h4000, RESP_OKAY);
    pressed <= 16'h0020;
    wait_irq(200);
    chk("irq scan once", 34'h1, {33'h0, irq});
    chk("key data parked", 34'h0, {18'h0, key_data});
    rd(IDX_CTRL, 16'hC000, RESP_OKAY);
    $display("test scan once done");
    pressed <= 16'h0000;
    wr(IDX_KEY_MASK, 16'h0200, RESP_OKAY);
    pressed <= 16'h0240;
    wr(IDX_CTRL, 16'h8000, RESP_OKAY);
    wait_irq(200);
    chk("irq auto mode", 34'h1, {33'h0, irq});
    t = 0;
    while (key_data !== 16'h0040 && t < 30000) begin
      @(posedge clock_in);
      t++;
    end
    chk("key data masked", 34'h0040, {18'h0, key_data});
    chk("debounce span", 34'h1, {33'h0, t >= 20000 && t < 20100});
    t = 0;
    while (oe_n[7:4] !== 4'h0 && t < 100) begin
      @(posedge clock_in);
      t++;
    end
    t = 0;
    while (oe_n[7:4] === 4'h0 && t < 2000) begin
      @(posedge clock_in);
      t++;
    end
    t = t - HOLD_SHORT_TICKS * TICK_CYCLES;
    chk("hold span", 34'h1, {33'h0, t >= 0 && t < 10});
    $display("test auto scan done");
    report_and_stop();
  end
endmodule : keypad_scan_controller_bench
